/* src/sff_cfg.svh */
/*
 Constants of the setup frame address filter: setup buffer layout,
 descriptor close value, hash parameters and transmit status fields.
 Assumes inclusion by bare name from the filter's source files.
*/
`ifndef SFF_CFG_SVH
`define SFF_CFG_SVH

`define SFF_SETUP_BYTES    192
`define SFF_SETUP_WORDS    48
`define SFF_WORD_BITS      16
`define SFF_PERFECT_SLOTS  16
`define SFF_HASH_BITS      512
`define SFF_HASH_PA_WORD   39
`define SFF_CLOSE_STATUS   32'h7fffffff
`define SFF_CRC_POLY       32'hedb88320
`define SFF_CRC_INIT       32'hffffffff
`define SFF_TXS_ES         15
`define SFF_TXS_TO         14
`define SFF_TXS_LO         11
`define SFF_TXS_NC         10
`define SFF_TXS_LC         9
`define SFF_TXS_EC         8
`define SFF_TXS_HF         7
`define SFF_TXS_CC_MSB     6
`define SFF_TXS_CC_LSB     3
`define SFF_TXS_UF         1
`define SFF_TXS_DE         0
`define SFF_TXS_DEFINED    16'hcffb

`endif

/* src/sff_pkg.sv */
/*
 Types of the setup frame address filter.
 Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package sff_pkg;
	typedef enum logic [1:0] {
		SFF_IDLE,
		SFF_WAIT,
		SFF_LOAD,
		SFF_CLOSE
	} sff_state_t;

	typedef enum logic [2:0] {
		SFF_END_OK,
		SFF_END_UNDERFLOW,
		SFF_END_EXCESS_COL,
		SFF_END_WATCHDOG,
		SFF_END_LOOPBACK
	} sff_end_t;
endpackage
`default_nettype wire

/* src/sff_hash_if.sv */
/*
 Carrier between the filter and its hash index unit.
 Assumes the index is a pure function of the address.
*/
`default_nettype none
interface sff_hash_if;
	logic [47:0] da;
	logic [8:0]  index;
	modport crc_mp  (input da, output index);
	modport user_mp (output da, input index);
endinterface
`default_nettype wire

/* src/sff_crc_hash.sv */
/*
 Hash index unit: Ethernet CRC over a 48-bit destination address.
 Assumes byte 0 of the address in bits 7:0, sent least bit first.
*/
`include "sff_cfg.svh"
`default_nettype none
module sff_crc_hash (
	sff_hash_if.crc_mp hif
);
	import sff_pkg::*;

	logic [31:0] crc;

	// Serial CRC, all-ones start, reflected polynomial
	always_comb begin
		crc = `SFF_CRC_INIT;
		for (int i = 0; i < 48; i++) begin
			if (crc[0] ^ hif.da[i]) begin
				crc = (crc >> 1) ^ `SFF_CRC_POLY;
			end else begin
				crc = crc >> 1;
			end
		end
		hif.index = crc[8:0];
	end
endmodule
`default_nettype wire

/* src/sff_filter.sv */
/*
 Setup frame loader and receive destination address filter, with the
 transmit completion status word and its validity mask.
 Assumes setup words arrive one 32-bit word per beat from descriptor
 DMA, and destination addresses one per pulse from the receive path.
*/
`include "sff_cfg.svh"
`default_nettype none
module sff_filter (
	input  wire logic           i_core_clk,
	input  wire logic           i_rstn,
	input  wire logic           i_setup_req,
	input  wire logic           i_setup_hash,
	input  wire logic           i_setup_inverse,
	input  wire logic           i_tx_running,
	input  wire logic           i_tx_idle,
	input  wire logic           i_rx_busy,
	input  wire logic           i_setup_valid,
	input  wire logic [31:0]    i_setup_word,
	input  wire logic           i_accept_all,
	input  wire logic           i_da_valid,
	input  wire logic [47:0]    i_da,
	input  wire logic           i_tx_end_valid,
	input  wire sff_pkg::sff_end_t i_tx_end_cause,
	input  wire logic [15:0]    i_tx_flags,
	output logic                o_setup_ready,
	output logic                o_rx_disengage,
	output logic                o_desc_wr,
	output logic [31:0]         o_desc_status,
	output logic                o_filter_hash,
	output logic                o_filter_inverse,
	output logic                o_da_done,
	output logic                o_da_accept,
	output logic                o_tx_status_valid,
	output logic [15:0]         o_tx_status_word,
	output logic [15:0]         o_tx_valid_mask
);
	import sff_pkg::*;

	localparam int NW = `SFF_SETUP_WORDS;

	sff_hash_if hif ();
	sff_crc_hash u_crc (.hif(hif));
	assign hif.da = i_da;

	// Setup sequencing state
	sff_state_t  st_ff, nxt_st;
	logic [5:0]  cnt_ff, nxt_cnt;
	logic        pend_hash_ff, nxt_pend_hash;
	logic        pend_inv_ff, nxt_pend_inv;
	logic        ready_ff, nxt_ready;
	logic        dis_ff, nxt_dis;
	logic        wr_ff, nxt_wr;
	logic [31:0] stat_ff, nxt_stat;
	logic        hash_ff, nxt_hash;
	logic        inv_ff, nxt_inv;
	logic        take;

	assign take = ready_ff && i_setup_valid;

	always_comb begin
		nxt_st        = st_ff;
		nxt_cnt       = cnt_ff;
		nxt_pend_hash = pend_hash_ff;
		nxt_pend_inv  = pend_inv_ff;
		nxt_hash      = hash_ff;
		nxt_inv       = inv_ff;
		nxt_stat      = stat_ff;
		unique case (st_ff)
			SFF_IDLE: begin
				if (i_setup_req) begin
					nxt_st        = SFF_WAIT;
					nxt_pend_hash = i_setup_hash;
					nxt_pend_inv  = i_setup_inverse;
				end
			end
			SFF_WAIT: begin
				if (i_tx_running && i_tx_idle && !i_rx_busy) begin
					nxt_st  = SFF_LOAD;
					nxt_cnt = 6'h00;
				end
			end
			SFF_LOAD: begin
				if (take) begin
					nxt_cnt = cnt_ff + 6'h01;
					if (cnt_ff == 6'(NW - 1)) begin
						nxt_st   = SFF_CLOSE;
						nxt_stat = `SFF_CLOSE_STATUS;
					end
				end
			end
			SFF_CLOSE: begin
				nxt_st   = SFF_IDLE;
				nxt_hash = pend_hash_ff;
				nxt_inv  = pend_inv_ff;
			end
		endcase
		nxt_ready = (nxt_st == SFF_LOAD);
		nxt_dis   = (nxt_st == SFF_LOAD) || (nxt_st == SFF_CLOSE);
		nxt_wr    = (nxt_st == SFF_CLOSE);
	end

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			st_ff        <= SFF_IDLE;
			cnt_ff       <= 6'h00;
			pend_hash_ff <= 1'b0;
			pend_inv_ff  <= 1'b0;
			ready_ff     <= 1'b0;
			dis_ff       <= 1'b0;
			wr_ff        <= 1'b0;
			stat_ff      <= 32'h0;
			hash_ff      <= 1'b0;
			inv_ff       <= 1'b0;
		end else begin
			st_ff        <= nxt_st;
			cnt_ff       <= nxt_cnt;
			pend_hash_ff <= nxt_pend_hash;
			pend_inv_ff  <= nxt_pend_inv;
			ready_ff     <= nxt_ready;
			dis_ff       <= nxt_dis;
			wr_ff        <= nxt_wr;
			stat_ff      <= nxt_stat;
			hash_ff      <= nxt_hash;
			inv_ff       <= nxt_inv;
		end
	end

	// Filter store: low half of each setup word, upper half dropped
	logic [15:0] words_ff [NW];
	logic [15:0] nxt_words [NW];

	always_comb begin
		nxt_words = words_ff;
		if (take) begin
			nxt_words[cnt_ff] = i_setup_word[15:0];
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			for (int i = 0; i < NW; i++) begin
				words_ff[i] <= 16'h0;
			end
		end else begin
			words_ff <= nxt_words;
		end
	end

	// Address decision
	logic        match;
	logic        hash_bit;
	logic [47:0] pa;
	logic        accept;
	logic        done_ff, nxt_done;
	logic        acc_ff, nxt_acc;

	always_comb begin
		match = 1'b0;
		for (int s = 0; s < `SFF_PERFECT_SLOTS; s++) begin
			if (i_da == {words_ff[3*s+2], words_ff[3*s+1],
				words_ff[3*s]}) begin
				match = 1'b1;
			end
		end
		hash_bit = words_ff[hif.index[8:4]][hif.index[3:0]];
		pa = {words_ff[`SFF_HASH_PA_WORD + 2],
			words_ff[`SFF_HASH_PA_WORD + 1],
			words_ff[`SFF_HASH_PA_WORD]};
		if (i_accept_all) begin
			accept = 1'b1;
		end else if (!hash_ff) begin
			accept = inv_ff ? !match : match;
		end else if (inv_ff) begin
			accept = hash_bit;
		end else if (i_da[0]) begin
			accept = hash_bit;
		end else begin
			accept = (i_da == pa);
		end
		nxt_done = i_da_valid && !dis_ff;
		nxt_acc  = nxt_done && accept;
	end

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			done_ff <= 1'b0;
			acc_ff  <= 1'b0;
		end else begin
			done_ff <= nxt_done;
			acc_ff  <= nxt_acc;
		end
	end

	// Transmit completion status and its validity
	logic        tv_ff, nxt_tv;
	logic [15:0] tw_ff, nxt_tw;
	logic [15:0] tm_ff, nxt_tm;
	logic [15:0] m;

	always_comb begin
		m = `SFF_TXS_DEFINED;
		unique case (i_tx_end_cause)
			SFF_END_UNDERFLOW: m[`SFF_TXS_EC] = 1'b0;
			SFF_END_EXCESS_COL: begin
				m[`SFF_TXS_CC_MSB:`SFF_TXS_CC_LSB] = 4'h0;
			end
			SFF_END_WATCHDOG: begin
				m[`SFF_TXS_LO] = 1'b0;
				m[`SFF_TXS_LC] = 1'b0;
				m[`SFF_TXS_EC] = 1'b0;
				m[`SFF_TXS_HF] = 1'b0;
			end
			SFF_END_LOOPBACK: begin
				m[`SFF_TXS_LO] = 1'b0;
				m[`SFF_TXS_NC] = 1'b0;
				m[`SFF_TXS_HF] = 1'b0;
			end
			default: m = `SFF_TXS_DEFINED;
		endcase
		nxt_tv = i_tx_end_valid;
		nxt_tw = tw_ff;
		nxt_tm = tm_ff;
		if (i_tx_end_valid) begin
			nxt_tw = i_tx_flags & `SFF_TXS_DEFINED;
			nxt_tm = m;
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			tv_ff <= 1'b0;
			tw_ff <= 16'h0;
			tm_ff <= 16'h0;
		end else begin
			tv_ff <= nxt_tv;
			tw_ff <= nxt_tw;
			tm_ff <= nxt_tm;
		end
	end

	assign o_setup_ready     = ready_ff;
	assign o_rx_disengage    = dis_ff;
	assign o_desc_wr         = wr_ff;
	assign o_desc_status     = stat_ff;
	assign o_filter_hash     = hash_ff;
	assign o_filter_inverse  = inv_ff;
	assign o_da_done         = done_ff;
	assign o_da_accept       = acc_ff;
	assign o_tx_status_valid = tv_ff;
	assign o_tx_status_word  = tw_ff;
	assign o_tx_valid_mask   = tm_ff;

	AST_NO_DA_DURING_LOAD: assert property (
		@(posedge i_core_clk) disable iff (!i_rstn)
		o_setup_ready |=> !o_da_done)
		else $error("address decided while setup loads");

	AST_CLOSE_VALUE: assert property (
		@(posedge i_core_clk) disable iff (!i_rstn)
		$fell(o_setup_ready) |-> o_desc_wr &&
			o_desc_status == 32'h7fffffff)
		else $error("setup descriptor closed with wrong value");

	AST_START_GATE: assert property (
		@(posedge i_core_clk) disable iff (!i_rstn)
		$rose(o_setup_ready) |-> $past(i_tx_running) &&
			$past(i_tx_idle) && !$past(i_rx_busy))
		else $error("setup started without idle transmit");

	AST_LOAD_LENGTH: assert property (
		@(posedge i_core_clk) disable iff (!i_rstn)
		$rose(o_setup_ready) && i_setup_valid [*1] ##1
			i_setup_valid [*8] |-> o_setup_ready)
		else $error("setup load ended early");

	AST_PERFECT_DECIDE: assert property (
		@(posedge i_core_clk) disable iff (!i_rstn)
		i_da_valid && !dis_ff && !hash_ff && !i_accept_all
		|=> o_da_accept == ($past(inv_ff) ^ $past(match)))
		else $error("perfect filter decision wrong");

	AST_GROUP_HASH: assert property (
		@(posedge i_core_clk) disable iff (!i_rstn)
		i_da_valid && !dis_ff && hash_ff && i_da[0] && !i_accept_all
		|=> o_da_accept == $past(hash_bit))
		else $error("group address not hash filtered");

	AST_UNICAST_PA: assert property (
		@(posedge i_core_clk) disable iff (!i_rstn)
		i_da_valid && !dis_ff && hash_ff && !inv_ff && !i_da[0] &&
		!i_accept_all |=> o_da_accept == ($past(i_da) == $past(pa)))
		else $error("unicast not compared to station address");

	AST_UNDERFLOW_MASK: assert property (
		@(posedge i_core_clk) disable iff (!i_rstn)
		i_tx_end_valid && i_tx_end_cause == SFF_END_UNDERFLOW
		|=> o_tx_status_valid && !o_tx_valid_mask[8] &&
			o_tx_valid_mask[15] && o_tx_valid_mask[0])
		else $error("underflow validity mask wrong");

	AST_WATCHDOG_MASK: assert property (
		@(posedge i_core_clk) disable iff (!i_rstn)
		i_tx_end_valid && i_tx_end_cause == SFF_END_WATCHDOG
		|=> o_tx_valid_mask[11:7] == 5'b01000 &&
			o_tx_valid_mask[6:3] == 4'hf)
		else $error("watchdog validity mask wrong");
endmodule
`default_nettype wire

/* verification/sff_host_model.sv */
/*
 Host side model: streams the 48-word setup buffer held in mem.
 Assumes the bench fills mem before each setup request.
*/
`default_nettype none
module sff_host_model (
	input  wire logic   i_core_clk,
	input  wire logic   i_ready,
	input  wire logic   i_slow,
	output logic        o_valid,
	output logic [31:0] o_word
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [48] = '{default: 16'h0};
	int          idx = 0;
	logic        tick = 0;
	logic        take;
	initial o_valid = 0;
	initial o_word = 0;
	// Index restarts whenever the filter is not loading
	always @(posedge i_core_clk) begin
		take = i_ready & o_valid;
		#1;
		idx = !i_ready ? 0 : idx + int'(take);
		tick = ~tick;
		o_valid = i_ready && idx < 48 && (!i_slow || tick);
		o_word = o_valid ? {~mem[idx % 48], mem[idx % 48]}
			: {mem[idx % 48], ~mem[idx % 48]};
	end
endmodule
`default_nettype wire

/* verification/tb.sv */
/*
 Bench of the setup frame address filter: loads, filtering, tx status.
 Assumes sff_host_model streams the setup words.
*/
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	import sff_pkg::*;
	logic         clk, rstn, req, sh, si, run, idle, busy, sval;
	logic         aall, dav, tev, slow;
	logic [31:0]  sw, dst;
	logic [47:0]  da, sta, u;
	logic [15:0]  tfl, tsw, tvm;
	sff_end_t     tec;
	logic         rdy, dis, dwr, fh, fi, dd, dac, tsv;
	logic [47:0]  addr [16];
	logic [511:0] tbl;
	logic [15:0]  msk [5] = '{16'hcffb, 16'hcefb, 16'hcf83, 16'hc47b,
		16'hc37b};
	int           failures = 0, num_checks = 0, cyc = 0;

	sff_filter u_dut (.i_core_clk(clk), .i_rstn(rstn), .i_setup_req(req),
		.i_setup_hash(sh), .i_setup_inverse(si), .i_tx_running(run),
		.i_tx_idle(idle), .i_rx_busy(busy), .i_setup_valid(sval),
		.i_setup_word(sw), .i_accept_all(aall), .i_da_valid(dav),
		.i_da(da), .i_tx_end_valid(tev), .i_tx_end_cause(tec),
		.i_tx_flags(tfl), .o_setup_ready(rdy), .o_rx_disengage(dis),
		.o_desc_wr(dwr), .o_desc_status(dst), .o_filter_hash(fh),
		.o_filter_inverse(fi), .o_da_done(dd), .o_da_accept(dac),
		.o_tx_status_valid(tsv), .o_tx_status_word(tsw),
		.o_tx_valid_mask(tvm));
	sff_host_model u_host (.i_core_clk(clk), .i_ready(rdy), .i_slow(slow),
		.o_valid(sval), .o_word(sw));

	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end

	task automatic finish_test;
		if (failures == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			failures++;
			finish_test;
		end
	end

	task automatic chk(input logic [47:0] s, input logic [47:0] e);
		num_checks++;
		if (s !== e) begin
			failures++;
			$display("[FAIL] %0t got %h want %h", $time, s, e);
		end
	endtask

	function automatic logic [8:0] hidx(input logic [47:0] a);
		logic [31:0] c;
		c = 32'hffffffff;
		for (int i = 0; i < 48; i++)
			c = (c >> 1) ^ ((c[0] ^ a[i]) ? 32'hedb88320 : 32'h0);
		return c[8:0];
	endfunction

	function automatic logic want(input logic [47:0] a);
		logic m;
		m = 0;
		if (aall)
			return 1;
		if (sh && (si || a[0]))
			return tbl[hidx(a)];
		if (sh)
			return a == sta;
		for (int k = 0; k < 16; k++)
			m |= (a == addr[k]);
		return m ^ si;
	endfunction

	task automatic da_chk(input logic [47:0] a);
		@(posedge clk) #1;
		dav = 1;
		da = a;
		@(posedge clk) #1;
		dav = 0;
		chk(dd, 1);
		chk(dac, want(a));
	endtask

	task automatic load(input logic h, input logic i, input logic g);
		@(posedge clk) #1;
		{req, sh, si} = {1'b1, h, i};
		@(posedge clk) #1;
		req = 0;
		for (int k = 0; g && k < 3; k++) begin
			{run, idle, busy} = {k != 0, k != 1, k == 2};
			repeat (3) @(posedge clk);
			#1 chk(rdy, 0);
		end
		{run, idle, busy} = 3'b110;
		for (int k = 0; k < 200 && !dwr; k++) begin
			@(posedge clk) #1;
			chk(dd, 0);
			dav = dis && !dwr;
		end
		chk(dwr, 1);
		chk(dst, 32'h7fffffff);
		chk(rdy, 0);
		@(posedge clk) #1;
		chk({fh, fi, dis, dwr}, {h, i, 1'b0, 1'b0});
	endtask

	initial begin
		{rstn, req, sh, si, run, idle, busy, aall, dav, tev, slow} = 0;
		{da, tfl, tbl} = 0;
		tec = SFF_END_OK;
		repeat (2) @(posedge clk);
		#1 rstn = 1;
		chk({rdy, dis, dwr, dst, fh, fi, dd, dac, tsv}, 0);
		for (int k = 0; k < 16; k++) begin
			addr[k] = (k == 15) ? addr[0] : {8'h5a, 32'h0, k[7:0]};
			for (int j = 0; j < 3; j++)
				u_host.mem[3 * k + j] = addr[k][16 * j +: 16];
		end
		load(0, 0, 1);
		for (int k = 0; k < 16; k++)
			da_chk(addr[k]);
		da_chk(addr[2] ^ 48'h800000000000);
		slow = 1;
		load(0, 1, 0);
		da_chk(addr[5]);
		da_chk(48'h5a0000000020);
		aall = 1;
		da_chk(addr[5]);
		aall = 0;
		sta = 48'h0876353412a8;
		u = 48'h3300220011aa;
		tbl[hidx(u)] = 1;
		for (int k = 0; k < 4; k++)
			tbl[hidx({40'h1234, k[7:0] * 8'h22 + 8'h1})] = 1;
		for (int w = 0; w < 48; w++)
			u_host.mem[w] = w < 32 ? tbl[16 * w +: 16] : 16'hffff;
		for (int j = 0; j < 3; j++)
			u_host.mem[39 + j] = sta[16 * j +: 16];
		slow = 0;
		load(1, 0, 0);
		for (int k = 0; k < 6; k++)
			da_chk({40'h1234, k[7:0] * 8'h22 + 8'h1});
		da_chk(sta);
		da_chk(u);
		load(1, 1, 0);
		da_chk(u);
		da_chk(sta);
		for (int c = 0; c < 5; c++) begin
			@(posedge clk) #1;
			{tev, tfl} = {1'b1, 16'hffff >> c};
			tec = sff_end_t'(c);
			@(posedge clk) #1;
			tev = 0;
			chk({tsv, tsw}, {1'b1, (16'hffff >> c) & 16'hcffb});
			chk(tvm, msk[c]);
		end
		finish_test;
	end
endmodule
`default_nettype wire
